// ### hdl/ddscw_pkg.sv
// Package for the synthesizer control word: addresses, fields, reset values, types
package ddscw_pkg;

   // Byte addresses of the control word, high byte first
   localparam logic [7:0] ADDR_CW_HI      = 8'h1d;
   localparam logic [7:0] ADDR_CW_LO      = 8'h20;

   // Field positions
   localparam int         BIT_CMP_PD      = 28;
   localparam int         BIT_HALT        = 27;
   localparam int         BIT_QDAC_PD     = 26;
   localparam int         BIT_DAC_PD      = 25;
   localparam int         BIT_DIG_PD      = 24;
   localparam int         BIT_PLL_RANGE   = 22;
   localparam int         BIT_PLL_BYPASS  = 21;
   localparam int         POS_PLL_MULT    = 16;
   localparam int         BIT_CLR_ACC1    = 15;
   localparam int         BIT_CLR_ACC     = 14;
   localparam int         BIT_TRIANGLE    = 13;
   localparam int         BIT_QDAC_SRC    = 12;
   localparam int         POS_MODE        = 9;
   localparam int         BIT_INT_UPDATE  = 8;
   localparam int         BIT_SINC_BYPASS = 6;
   localparam int         BIT_KEY_EN      = 5;
   localparam int         BIT_KEY_INT     = 4;
   localparam int         BIT_LSB_FIRST   = 1;
   localparam int         BIT_SDO_ACTIVE  = 0;

   // Bits that hold state; unused, reserved and self-clearing bits read zero
   localparam logic [31:0] CW_STORE_MASK  = 32'h1f7f_7f73;
   // Power-up value: PLL range high, PLL bypassed, multiplier field zero
   localparam logic [31:0] CW_RESET       = 32'h0060_0000;

   // Multiplier limits the host must respect
   localparam logic [4:0] PLL_MULT_MIN    = 5'h04;
   localparam logic [4:0] PLL_MULT_MAX    = 5'h14;

   // Operating modes
   typedef enum logic [2:0] {
      DDSCW_SINGLE_TONE = 3'h0,
      DDSCW_FSK         = 3'h1,
      DDSCW_RAMPED_FSK  = 3'h2,
      DDSCW_CHIRP       = 3'h3,
      DDSCW_BPSK        = 3'h4
   } ddscw_mode_e;

   // Decoded controls sent to the analog and digital sections
   typedef struct packed {
      logic        cmp_pd;
      logic        qdac_pd;
      logic        dac_pd;
      logic        dig_clk_stop;
      logic        pll_range;
      logic        pll_bypass;
      logic        pll_pd;
      logic [4:0]  pll_mult;
      logic        acc_hold;
      logic        triangle;
      logic        qdac_src;
      logic [2:0]  mode;
      logic        sinc_bypass;
      logic        sinc_clk_stop;
      logic        key_en;
      logic        key_int;
      logic        lsb_first;
      logic        sdo_active;
   } ddscw_ctrl_s;

   // Byte lane of the control word for a given address (0 = bits 31:24)
   function automatic logic [1:0] ddscw_lane(input logic [7:0] addr);
      logic [7:0] d;
      d = addr - ADDR_CW_HI;
      return d[1:0];
   endfunction

   // True when the address falls inside the control word
   function automatic logic ddscw_hit(input logic [7:0] addr);
      return (addr >= ADDR_CW_HI) && (addr <= ADDR_CW_LO);
   endfunction

endpackage

// ### hdl/ddscw_pulse.sv
// One-clock delay stage for the accumulator 1 clear request pulse
`timescale 1ns/1ps
module ddscw_pulse
   import ddscw_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic trig,
   output logic      pulse
);

   logic next_pulse;

   // Pulse follows the trigger by one clock
   always_comb begin
      next_pulse = trig;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pulse <= 1'b0;
      end else begin
         pulse <= next_pulse;
      end
   end

endmodule // ddscw_pulse

// ### hdl/ddscw_reg.sv
// Synthesizer control word: byte-wide port, buffered writes, update transfer, decode
//
// Overview of operation
// R1: Word at bytes 1d..20, bit 31 highest
// R2: Bits 31:29 unused; reserved bits written zero
// R3: Bit 28 powers down the comparator
// R4: Bit 27 set halts device until reset
// R5: Bit 26 powers down Q DAC only
// R6: Bit 25 powers down both DACs, reference
// R7: Bit 24 stops digital clocks, PLL runs
// R8: Bit 22 selects VCO gain, resets one
// R9: Bit 21 bypasses PLL, resets one
// R10: Bits 20:16 multiplier, host uses 4..20
// R11: Bit 15 pulses accumulator 1 clear, self-clears
// R12: Bit 14 holds both accumulators at zero
// R13: Bit 13 triangle sweep, needs ramped FSK
// R14: Bit 12 feeds Q DAC from register
// R15: Bits 11:9 select operating mode
// R16: Bit 8 makes update pin an output
// R17: Bit 6 bypasses inverse sinc, stops clock
// R18: Bit 5 enables output amplitude ramping
// R19: Bit 4 internal keying factor, else registers
// R20: Bit 1 selects LSB-first serial order
// R21: Bit 0 enables separate serial output
// R22: Port format changes on update, mid-transfer
// R23: Separate output tri-stated when inactive
// R24: Host sends instruction LSB first too
// R25: Reads return settings; unused bits zero
`timescale 1ns/1ps
module ddscw_reg
   import ddscw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        wr_en,
   input  wire logic [7:0]  rd_addr,
   output logic [7:0]       rd_data,
   input  wire logic        update_in,
   input  wire logic        update_gen,
   output logic             update_out,
   output logic             update_oe,
   input  wire logic        sdo_bit,
   input  wire logic        sdo_drive,
   output logic             sdo_out,
   output logic             sdo_oe,
   output ddscw_ctrl_s      ctrl,
   output logic             clr_acc1_pulse,
   output logic             halted
);

   // Buffer memory written by the host, and the active word
   logic [31:0]   buffer;
   logic [31:0]   active;
   logic [31:0]   next_buffer;
   logic [31:0]   next_active;
   logic          clr_req;
   logic          next_clr_req;
   logic          halt;
   logic          next_halt;
   logic          upd_ev;
   logic          clr_trig;

   // Output stage registers
   logic [7:0]    next_rd_data;
   ddscw_ctrl_s   next_ctrl;
   logic          next_update_out;
   logic          next_update_oe;
   logic          next_sdo_out;
   logic          next_sdo_oe;

   // Update source follows the pin direction in the active word
   assign upd_ev = active[BIT_INT_UPDATE] ? update_gen : update_in;   // [R16]

   // Host byte writes land in the buffer; update moves it to the active word
   always_comb begin
      next_buffer  = buffer;
      next_active  = active;
      next_clr_req = 1'b0;
      next_halt    = halt;
      if (wr_en && ddscw_hit(wr_addr) && !halt) begin
         // Lane 0 carries bits 31:24, lane 3 bits 7:0 [R1]
         case (ddscw_lane(wr_addr))
            2'h0:    next_buffer[31:24] = wr_data;
            2'h1:    next_buffer[23:16] = wr_data;
            2'h2:    next_buffer[15:8]  = wr_data;
            default: next_buffer[7:0]   = wr_data;
         endcase
      end
      if (upd_ev && !halt) begin
         // Whole word applies at once, so port format changes mid-transfer [R22]
         next_active  = next_buffer & CW_STORE_MASK;   // [R2] [R25]
         // Clear request is one-shot and never stored [R11]
         next_clr_req = next_buffer[BIT_CLR_ACC1];
         next_buffer[BIT_CLR_ACC1] = 1'b0;
         // A one here freezes the device; only rst_b recovers it [R4]
         if (next_buffer[BIT_HALT]) begin
            next_halt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         buffer  <= CW_RESET;
         active  <= CW_RESET;   // [R8] [R9]
         clr_req <= 1'b0;
         halt    <= 1'b0;
      end else begin
         buffer  <= next_buffer;
         active  <= next_active;
         clr_req <= next_clr_req;
         halt    <= next_halt;
      end
   end

   assign clr_trig = clr_req & ~halt;

   // Single-cycle accumulator 1 clear toward the DDS core
   ddscw_pulse u_pulse (
      .clk   (clk),
      .rst_b (rst_b),
      .trig  (clr_trig),
      .pulse (clr_acc1_pulse)   // [R11]
   );

   // Decode of the active word into section controls
   always_comb begin
      next_ctrl               = '0;
      next_ctrl.cmp_pd        = active[BIT_CMP_PD];                       // [R3]
      next_ctrl.qdac_pd       = active[BIT_QDAC_PD] | active[BIT_DAC_PD]; // [R5]
      next_ctrl.dac_pd        = active[BIT_DAC_PD];                       // [R6]
      // Halt also stops the digital clocks; PLL is left alone [R7]
      next_ctrl.dig_clk_stop  = active[BIT_DIG_PD] | halt;
      next_ctrl.pll_range     = active[BIT_PLL_RANGE];                    // [R8]
      next_ctrl.pll_bypass    = active[BIT_PLL_BYPASS];                   // [R9]
      next_ctrl.pll_pd        = active[BIT_PLL_BYPASS];                   // [R9]
      // Multiplier passed as written; range 4..20 is the host's duty [R10]
      next_ctrl.pll_mult      = active[POS_PLL_MULT +: 5];
      next_ctrl.acc_hold      = active[BIT_CLR_ACC];                      // [R12]
      next_ctrl.triangle      = active[BIT_TRIANGLE];                     // [R13]
      next_ctrl.qdac_src      = active[BIT_QDAC_SRC];                     // [R14]
      next_ctrl.mode          = active[POS_MODE +: 3];                    // [R15]
      next_ctrl.sinc_bypass   = active[BIT_SINC_BYPASS];                  // [R17]
      next_ctrl.sinc_clk_stop = active[BIT_SINC_BYPASS];                  // [R17]
      next_ctrl.key_en        = active[BIT_KEY_EN];                       // [R18]
      next_ctrl.key_int       = active[BIT_KEY_INT];                      // [R19]
      next_ctrl.lsb_first     = active[BIT_LSB_FIRST];                    // [R20] [R24]
      next_ctrl.sdo_active    = active[BIT_SDO_ACTIVE];                   // [R21]
   end

   // Read mux: active settings by byte lane, zero off the map
   always_comb begin
      next_rd_data = 8'h00;
      if (ddscw_hit(rd_addr)) begin
         case (ddscw_lane(rd_addr))
            2'h0:    next_rd_data = active[31:24];   // [R25]
            2'h1:    next_rd_data = active[23:16];
            2'h2:    next_rd_data = active[15:8];
            default: next_rd_data = active[7:0];
         endcase
      end
   end

   // Pin drivers; internal strobe is only driven when the pin is an output
   always_comb begin
      next_update_oe  = active[BIT_INT_UPDATE];                  // [R16]
      next_update_out = active[BIT_INT_UPDATE] & update_gen;     // [R16]
      // Separate output floats unless enabled and the port is reading [R23]
      next_sdo_oe     = active[BIT_SDO_ACTIVE] & sdo_drive;      // [R21] [R23]
      next_sdo_out    = next_sdo_oe & sdo_bit;
   end

   // Output flops; a registered pin lags its cause by one clock
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data    <= 8'h00;
         ctrl       <= '0;
         update_out <= 1'b0;
         update_oe  <= 1'b0;
         sdo_out    <= 1'b0;
         sdo_oe     <= 1'b0;
         halted     <= 1'b0;
      end else begin
         rd_data    <= next_rd_data;
         ctrl       <= next_ctrl;
         update_out <= next_update_out;
         update_oe  <= next_update_oe;
         sdo_out    <= next_sdo_out;
         sdo_oe     <= next_sdo_oe;
         halted     <= halt;
      end
   end

endmodule // ddscw_reg

// ### tb/ddscw_reg_assertions.sv
// Property checker for the control word register bank
`timescale 1ns/1ps
module ddscw_reg_assertions
   import ddscw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  rd_addr,
   input  wire logic [7:0]  rd_data,
   input  wire logic        update_gen,
   input  wire logic        update_out,
   input  wire logic        update_oe,
   input  wire logic        sdo_drive,
   input  wire logic        sdo_oe,
   input  wire logic        sdo_bit,
   input  wire logic        sdo_out,
   input  wire ddscw_ctrl_s ctrl,
   input  wire logic        clr_acc1_pulse,
   input  wire logic        halted
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Clear pulse lasts one cycle; halt settles for a few cycles first
   sequence one_pulse_s;
      clr_acc1_pulse ##1 !clr_acc1_pulse;
   endsequence
   sequence stuck_s;
      halted [*3];
   endsequence
   pulse_one_a:
      assert property ($rose(clr_acc1_pulse) |-> one_pulse_s) else $error("clear pulse too long");
   halt_hold_a:
      assert property (halted |=> halted) else $error("halt released without reset");
   halt_freeze_a:
      assert property (stuck_s |-> $stable(ctrl) && ctrl.dig_clk_stop) else $error("halt not frozen");
   upd_dir_a:
      assert property (update_out |-> update_oe) else $error("update out while pin is input");
   upd_gen_a:
      assert property (update_oe && $past(update_gen) |-> update_out) else $error("update lost");
   sdo_oe_a:
      assert property (sdo_oe == (ctrl.sdo_active && $past(sdo_drive))) else $error("sdo enable");
   sdo_data_a:
      assert property (sdo_out == (sdo_oe && $past(sdo_bit))) else $error("sdo data leaks");
   qdac_pd_a:
      assert property (ctrl.dac_pd |-> ctrl.qdac_pd) else $error("q dac stays powered");
   pll_pd_a:
      assert property (ctrl.pll_pd == ctrl.pll_bypass) else $error("pll power mismatch");
   off_map_a:
      assert property (rd_addr < 8'h1d || rd_addr > 8'h20 |=> rd_data == 8'h00)
         else $error("off-map read not zero");
endmodule // ddscw_reg_assertions
bind ddscw_reg ddscw_reg_assertions i_ddscw_reg_assertions (.clk(clk), .rst_b(rst_b),
   .rd_addr(rd_addr), .rd_data(rd_data), .update_gen(update_gen), .update_out(update_out),
   .update_oe(update_oe), .sdo_drive(sdo_drive), .sdo_oe(sdo_oe), .ctrl(ctrl),
   .sdo_bit(sdo_bit), .sdo_out(sdo_out),
   .clr_acc1_pulse(clr_acc1_pulse), .halted(halted));

// ### tb/ddscw_host.sv
// Host controller model: byte writes and update strobes
`timescale 1ns/1ps
module ddscw_host
   import ddscw_pkg::*;
(
   input  wire logic clk,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic       wr_en,
   output logic       update_in,
   output logic       update_gen
);
   initial begin
      wr_addr = 8'h00;
      wr_data = 8'h00;
      wr_en = 1'b0;
      update_in = 1'b0;
      update_gen = 1'b0;
   end
   // Four bytes back to back; released lines show inverted data
   task automatic wr_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) #1;
         wr_en = 1'b1;
         wr_addr = ADDR_CW_HI + 8'(i);
         wr_data = w[31-8*i -: 8];
      end
      @(posedge clk) #1;
      wr_en = 1'b0;
      wr_addr = ~wr_addr;
      wr_data = ~wr_data;
   endtask
   // One-cycle strobe on the source that the pin direction selects
   task automatic upd(input logic internal);
      @(posedge clk) #1;
      if (internal) update_gen = 1'b1;
      else update_in = 1'b1;
      @(posedge clk) #1;
      update_gen = 1'b0;
      update_in = 1'b0;
   endtask
endmodule // ddscw_host

// ### tb/ddscw_reg_tb_top.sv
// Self-checking bench for the control word register bank
`timescale 1ns/1ps
module ddscw_reg_tb_top;
   import ddscw_pkg::*;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
   logic        clk, rst_b, wr_en, update_in, update_gen, update_out, update_oe;
   logic [7:0]  wr_addr, wr_data, rd_addr, rd_data;
   logic        sdo_bit, sdo_drive, sdo_out, sdo_oe, clr_acc1_pulse, halted;
   ddscw_ctrl_s ctrl;
   logic [31:0] lfsr, cur, buff, w;
   int          error_cnt, checks, pcnt;
   ddscw_reg i_ddscw_reg (.clk(clk), .rst_b(rst_b), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_addr(rd_addr), .rd_data(rd_data), .update_in(update_in),
      .update_gen(update_gen), .update_out(update_out), .update_oe(update_oe),
      .sdo_bit(sdo_bit), .sdo_drive(sdo_drive), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .ctrl(ctrl), .clr_acc1_pulse(clr_acc1_pulse), .halted(halted));
   ddscw_host i_ddscw_host (.clk(clk), .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en),
      .update_in(update_in), .update_gen(update_gen));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Pulse counter, so a doubled clear pulse shows up
   always @(posedge clk) pcnt <= pcnt + int'(clr_acc1_pulse);
   // Random drive requests on the separate serial output
   always @(posedge clk) begin
      #1;
      sdo_drive <= sdo_drive ^ lfsr[3];
      sdo_bit <= lfsr[5];
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected decode of an active word
   function automatic ddscw_ctrl_s ex(input logic [31:0] v);
      return {v[28], v[26] | v[25], v[25], v[24] | v[27], v[22], v[21], v[21], v[20:16],
              v[14], v[13], v[12], v[11:9], v[6], v[6], v[5], v[4], v[1], v[0]};
   endfunction
   // Optional write, one update, then decode, pulse and read-back checks
   task automatic apply(input logic wr, input logic [31:0] v);
      int p;
      logic [31:0] m;
      if (wr) i_ddscw_host.wr_word(v);
      if (wr && !cur[27]) buff = v;
      i_ddscw_host.upd(cur[8]);
      p = pcnt;
      if (!cur[27]) cur = buff;
      buff[15] = 1'b0;
      m = cur & 32'h1f7f_7f73;
      @(posedge clk) #1;
      `CHK(ctrl, ex(cur))
      `CHK(update_oe, cur[8])
      `CHK(halted, cur[27])
      repeat (2) @(posedge clk) #1;
      `CHK(pcnt - p, int'(cur[15]))
      for (int i = 0; i < 4; i++) begin
         rd_addr = 8'h1d + 8'(i);
         @(posedge clk) #1;
         `CHK(rd_data, m[31-8*i -: 8])
      end
      rd_addr = lfsr[7:0];
   endtask
   task automatic stop_test();
      $display("errors=%0d checks=%0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      rd_addr = 8'h00;
      sdo_bit = 1'b0;
      sdo_drive = 1'b0;
      lfsr = 32'h5;
      cur = 32'h0060_0000;
      buff = cur;
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      apply(1'b0, 32'h0);
      apply(1'b1, 32'h0000_8000);
      apply(1'b0, 32'h0);
      for (int k = 0; k < 5; k++)
         apply(1'b1, {11'h0, k[0] ? 5'h14 : 5'h04, 2'h0, 1'(k == 2), 1'b0, 3'(k), 9'h0});
      repeat (30) begin
         lfsr = nxt(lfsr);
         w = lfsr & 32'hf77f_ff73;
         w[20:16] = 5'h04 + 5'(lfsr[31:27] % 17);
         w[11:9] = 3'(lfsr[26:24] % 5);
         if (w[13]) w[11:9] = 3'h2;
         apply(1'b1, w);
      end
      apply(1'b1, 32'h0800_0000);
      apply(1'b1, 32'h0000_0001);
      stop_test();
   end
   initial begin
      #200_000;
      error_cnt++;
      stop_test();
   end
endmodule // ddscw_reg_tb_top
